// >>> common/line_unit_map.vh
// line_unit_map.vh - offsets, field positions, reset values and timing counts
// for the line unit global control block; definitions only
`ifndef LINE_UNIT_MAP_VH
`define LINE_UNIT_MAP_VH

// register offsets (byte addresses on the microprocessor port)
`define GCR0_ADDR        12'hfe0
`define SEG8_ADDR        12'hfe8
`define EQC_ADDR_BASE    12'hf00
// field positions in global control register zero
`define RAIL_SELECT_BIT  7
`define AUTO_ONES_BIT    6
`define RX_EDGE_BIT      5
`define TX_EDGE_BIT      4
`define POLARITY_BIT     3
`define INT_GATE_BIT     1
`define SW_RESET_BIT     0
// pulse segment field: sign at top, magnitude below
`define SEG_SIGN_BIT     6
`define SEG_MAG_MSB      5
// equalizer control code that selects arbitrary pulse mode
`define EQC_ARBITRARY    5'h1f
// reset values
`define GCR0_RESET       8'h00
`define SEG8_RESET       8'h00
// software reset hold time in ns, and clock period in ns
`define SW_RESET_HOLD_NS 10000
`define CLK_PERIOD_NS    40
`define SW_RESET_CYCLES  ((`SW_RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> src/line_unit_global_control.v
// line_unit_global_control.v - global control register zero, the eighth
// pulse segment register, bypass rail timing, interrupt gating, soft reset.
// assumes an 8-bit asynchronous-style register port synchronous to sys_clk_in,
// and a bypass link clock arriving from outside, sampled by sys_clk_in.
`timescale 1ns/1ps
`include "line_unit_map.vh"

module line_unit_global_control
(
	// clock, reset, enable
	input  wire        sys_clk_in,
	input  wire        rst_b_in,
	input  wire        clk_en_in,
	// microprocessor register port
	input  wire        reg_sel_in,
	input  wire        reg_wr_in,
	input  wire [11:0] reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	output reg  [7:0]  reg_rdata_out,
	// per-channel state from the line unit
	input  wire [7:0]  receive_signal_loss_in,
	input  wire [4:0]  equalizer_control_in,
	input  wire [7:0]  source_status_in,
	input  wire [7:0]  source_enable_in,
	// bypass link from external framer logic
	input  wire        receive_line_clock_in,
	input  wire        transmit_line_clock_in,
	input  wire        transmit_positive_rail_in,
	input  wire        transmit_negative_rail_in,
	input  wire        recovered_positive_in,
	input  wire        recovered_negative_in,
	output reg         receive_positive_rail_out,
	output reg         receive_negative_rail_out,
	output reg         line_positive_out,
	output reg         line_negative_out,
	// controls and status
	output reg  [6:0]  pulse_segment_eight_out,
	output wire        pulse_segment_active_out,
	output wire        rail_select_out,
	output reg  [7:0]  all_ones_out,
	output reg         line_interrupt_out,
	output reg         internal_reset_b_out
);

	reg  [7:0]  gcr0;
	reg  [7:0]  seg8;
	reg  [13:0] hold_count;
	reg  [1:0]  rx_clk_sync;
	reg  [1:0]  tx_clk_sync;
	reg  [1:0]  transmit_positive_rail_sync;
	reg  [1:0]  transmit_negative_rail_sync;
	reg         rx_clk_last;
	reg         tx_clk_last;
	reg         soft_reset_b;
	wire        write_gcr0;
	wire        write_seg8;
	wire        rx_rise;
	wire        rx_fall;
	wire        tx_rise;
	wire        tx_fall;
	wire        rx_update;
	wire        tx_sample;
	wire        polarity;
	wire [7:0]  masked_source;
	reg  [2:0]  sr_state;
	reg  [2:0]  next_sr_state;
	reg  [13:0] next_hold_count;
	genvar      ch;

	localparam [2:0] SR_IDLE  = 3'b001;
	localparam [2:0] SR_COUNT = 3'b010;
	localparam [2:0] SR_FIRE  = 3'b100;

	// either edge of a sampled clock, chosen by a select bit
	function edge_pick;
		input sel_rise;
		input rise;
		input fall;
		begin
			edge_pick = sel_rise ? rise : fall;
		end
	endfunction

	// full-width address match, shared by the write strobes and the read mux
	function addr_hit;
		input [11:0] addr;
		input [11:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	assign write_gcr0 = reg_sel_in & reg_wr_in & addr_hit(reg_addr_in, `GCR0_ADDR);
	assign write_seg8 = reg_sel_in & reg_wr_in & addr_hit(reg_addr_in, `SEG8_ADDR);
	assign polarity   = gcr0[`POLARITY_BIT];
	assign rail_select_out = gcr0[`RAIL_SELECT_BIT];
	assign pulse_segment_active_out = (equalizer_control_in == `EQC_ARBITRARY);

	// registers: untouched by the soft reset, only the pin reset clears them
	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			gcr0 <= `GCR0_RESET;
			seg8 <= `SEG8_RESET;
		end
		else if (clk_en_in)
		begin
			if (write_gcr0)
				gcr0 <= reg_wdata_in;
			if (write_seg8)
				seg8 <= reg_wdata_in;
		end
	end

	always @*
	begin
		reg_rdata_out = 8'h00;
		if (addr_hit(reg_addr_in, `GCR0_ADDR))
			reg_rdata_out = {gcr0[7:3], 1'b0, gcr0[1:0]};
		else if (addr_hit(reg_addr_in, `SEG8_ADDR))
			reg_rdata_out = seg8;
	end

	// soft reset only after the bit has stood the full hold time;
	// clearing the bit at any point drops back to idle, so short pulses do nothing
	always @*
	begin
		next_sr_state   = sr_state;
		next_hold_count = hold_count;
		case (sr_state)
			SR_IDLE:
			begin
				next_hold_count = 14'h0000;
				if (gcr0[`SW_RESET_BIT])
					next_sr_state = SR_COUNT;
			end
			SR_COUNT:
			begin
				if (!gcr0[`SW_RESET_BIT])
				begin
					next_sr_state   = SR_IDLE;
					next_hold_count = 14'h0000;
				end
				else if (hold_count > `SW_RESET_CYCLES)
					next_sr_state = SR_FIRE;
				else
					next_hold_count = hold_count + 14'h0001;
			end
			SR_FIRE:
			begin
				if (!gcr0[`SW_RESET_BIT])
				begin
					next_sr_state   = SR_IDLE;
					next_hold_count = 14'h0000;
				end
			end
			default:
			begin
				next_sr_state   = SR_IDLE;
				next_hold_count = 14'h0000;
			end
		endcase
	end

	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sr_state     <= SR_IDLE;
			hold_count   <= 14'h0000;
			soft_reset_b <= 1'b1;
		end
		else if (clk_en_in)
		begin
			sr_state     <= next_sr_state;
			hold_count   <= next_hold_count;
			soft_reset_b <= (next_sr_state != SR_FIRE);
		end
	end

	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			internal_reset_b_out <= 1'b0;
		else if (clk_en_in)
			internal_reset_b_out <= soft_reset_b;
	end

	// link clocks and transmit rails pass two flops before any logic reads them; the recovered rails are read directly
	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rx_clk_sync <= 2'h0;
			tx_clk_sync <= 2'h0;
			transmit_positive_rail_sync   <= 2'h0;
			transmit_negative_rail_sync   <= 2'h0;
			rx_clk_last <= 1'b0;
			tx_clk_last <= 1'b0;
		end
		else if (clk_en_in)
		begin
			rx_clk_sync <= {rx_clk_sync[0], receive_line_clock_in};
			tx_clk_sync <= {tx_clk_sync[0], transmit_line_clock_in};
			transmit_positive_rail_sync   <= {transmit_positive_rail_sync[0], transmit_positive_rail_in};
			transmit_negative_rail_sync   <= {transmit_negative_rail_sync[0], transmit_negative_rail_in};
			rx_clk_last <= rx_clk_sync[1];
			tx_clk_last <= tx_clk_sync[1];
		end
	end

	assign rx_rise   = rx_clk_sync[1] & ~rx_clk_last;
	assign rx_fall   = ~rx_clk_sync[1] & rx_clk_last;
	assign tx_rise   = tx_clk_sync[1] & ~tx_clk_last;
	assign tx_fall   = ~tx_clk_sync[1] & tx_clk_last;
	assign rx_update = edge_pick(~gcr0[`RX_EDGE_BIT], rx_rise, rx_fall);
	assign tx_sample = edge_pick(gcr0[`TX_EDGE_BIT], tx_rise, tx_fall);

	// receive rails; idle at the polarity level while the soft reset stands
	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			receive_positive_rail_out <= 1'b0;
			receive_negative_rail_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (!soft_reset_b)
			begin
				receive_positive_rail_out <= polarity;
				receive_negative_rail_out <= polarity;
			end
			else if (rx_update)
			begin
				receive_positive_rail_out <= recovered_positive_in ^ polarity;
				receive_negative_rail_out <= recovered_negative_in ^ polarity;
			end
		end
	end

	// transmit rails, polarity undone so the line side always sees active high
	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			line_positive_out <= 1'b0;
			line_negative_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (!soft_reset_b)
			begin
				line_positive_out <= 1'b0;
				line_negative_out <= 1'b0;
			end
			else if (tx_sample)
			begin
				line_positive_out <= transmit_positive_rail_sync[1] ^ polarity;
				line_negative_out <= transmit_negative_rail_sync[1] ^ polarity;
			end
		end
	end

	// segment value and interrupt level
	always @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pulse_segment_eight_out <= 7'h00;
			line_interrupt_out      <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (!soft_reset_b)
			begin
				pulse_segment_eight_out <= 7'h00;
				line_interrupt_out      <= 1'b0;
			end
			else
			begin
				// zero when not in arbitrary mode so the shaper ignores it
				pulse_segment_eight_out <= pulse_segment_active_out ?
					{seg8[`SEG_SIGN_BIT], seg8[`SEG_MAG_MSB:0]} : 7'h00;
				line_interrupt_out <= gcr0[`INT_GATE_BIT] & (|masked_source);
			end
		end
	end

	// per-channel source masking and all-ones requests
	generate
		for (ch = 0; ch < 8; ch = ch + 1)
		begin : lane
			assign masked_source[ch] = source_status_in[ch] & source_enable_in[ch];
			always @(posedge sys_clk_in or negedge rst_b_in)
			begin
				if (!rst_b_in)
					all_ones_out[ch] <= 1'b0;
				else if (clk_en_in)
				begin
					if (!soft_reset_b)
						all_ones_out[ch] <= 1'b0;
					else
						all_ones_out[ch] <= gcr0[`AUTO_ONES_BIT] & receive_signal_loss_in[ch];
				end
			end
		end
	endgenerate

endmodule // line_unit_global_control

// >>> tb/framer_link_model.sv
// far-side framer: bypass link clock and transmit rails
// assumes run_in frames traffic; the clock stands still outside frames
`timescale 1ns/1ps
module framer_link_model(
	input wire run_in, tx_edge_in, pol_in,
	input wire [1:0] bits_in,
	output reg clk_out = 1'b0,
	output reg [1:0] rails_out = 2'b00);
	always
	begin
		#160;
		if (run_in)
			clk_out = ~clk_out;
		// launch on the edge the device does not sample
		if (run_in && clk_out != tx_edge_in)
			rails_out = bits_in ^ {2{pol_in}};
	end
endmodule // framer_link_model

// >>> tb/lu_gc_asserts.sv
// checker for the line unit global control block
// assumes a bind onto the design; mirrors registers from its write port
`timescale 1ns/1ps
module lu_gc_asserts(
	// clock, reset, register port
	input wire sys_clk_in, rst_b_in, clk_en_in, reg_sel_in, reg_wr_in,
	input wire [11:0] reg_addr_in,
	input wire [7:0] reg_wdata_in, reg_rdata_out, all_ones_out,
	// line state and outputs
	input wire [7:0] receive_signal_loss_in, source_status_in, source_enable_in,
	input wire [4:0] equalizer_control_in,
	input wire [6:0] pulse_segment_eight_out,
	input wire recovered_positive_in, receive_positive_rail_out,
	input wire pulse_segment_active_out, line_interrupt_out, internal_reset_b_out);
	reg [7:0] g, s, a;
	reg [6:0] sg;
	reg [8:0] n;
	reg q;
	wire [7:0] rd = (reg_addr_in == 12'hfe0) ? (g & 8'hfb) : (reg_addr_in == 12'hfe8) ? s : 8'h00;
	wire w = reg_sel_in & reg_wr_in;
	always @(posedge sys_clk_in or negedge rst_b_in)
		if (!rst_b_in)
			{g, s, a, sg, n, q} <= 41'h0;
		else if (clk_en_in)
		begin
			q <= g[1] & |(source_status_in & source_enable_in);
			a <= receive_signal_loss_in & {8{g[6]}};
			sg <= (equalizer_control_in == 5'h1f) ? s[6:0] : 7'h00;
			// saturates so a long hold cannot wrap
			n <= !g[0] ? 9'h000 : n + {8'h00, n != 9'h1ff};
			if (w && reg_addr_in == 12'hfe0) g <= reg_wdata_in;
			if (w && reg_addr_in == 12'hfe8) s <= reg_wdata_in;
		end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	chk_int_blocked: assert property (!g[1] |=> !line_interrupt_out)
		else $error("interrupt leaked");
	chk_int_sources: assert property (line_interrupt_out == q)
		else $error("interrupt wrong");
	chk_all_ones: assert property (all_ones_out == a)
		else $error("all ones wrong");
	chk_seg_value: assert property (pulse_segment_eight_out == sg)
		else $error("segment wrong");
	chk_seg_mode: assert property (pulse_segment_active_out == (equalizer_control_in == 5'h1f))
		else $error("mode wrong");
	chk_read_back: assert property (reg_sel_in |-> reg_rdata_out == rd)
		else $error("read wrong");
	chk_reset_early: assert property (!internal_reset_b_out && g[0] |-> n > 9'd249)
		else $error("soft reset early");
	chk_rx_value: assert property ($changed(receive_positive_rail_out) && internal_reset_b_out
		|-> receive_positive_rail_out == ($past(recovered_positive_in) ^ $past(g[3])))
		else $error("rail wrong");
endmodule // lu_gc_asserts
bind line_unit_global_control lu_gc_asserts lu_gc_asserts_i(
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
	.reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .all_ones_out(all_ones_out),
	.receive_signal_loss_in(receive_signal_loss_in), .source_status_in(source_status_in),
	.source_enable_in(source_enable_in), .equalizer_control_in(equalizer_control_in),
	.pulse_segment_eight_out(pulse_segment_eight_out),
	.recovered_positive_in(recovered_positive_in),
	.receive_positive_rail_out(receive_positive_rail_out),
	.pulse_segment_active_out(pulse_segment_active_out),
	.line_interrupt_out(line_interrupt_out), .internal_reset_b_out(internal_reset_b_out));

// >>> tb/test_line_unit_global_control.sv
// self-checking bench for the line unit global control block
// assumes the framer model on the bypass pins
`timescale 1ns/1ps
module test_line_unit_global_control;
	reg sys_clk_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, reg_sel_in = 1'b0, reg_wr_in = 1'b0;
	reg recovered_positive_in = 1'b0, recovered_negative_in = 1'b0, run = 1'b0, pol = 1'b0;
	reg [11:0] reg_addr_in = 12'h000;
	reg [7:0] reg_wdata_in = 8'h00, receive_signal_loss_in = 8'h00;
	reg [7:0] source_status_in = 8'h00, source_enable_in = 8'h00;
	reg [4:0] equalizer_control_in = 5'h00;
	reg [1:0] bits = 2'b00;
	wire [7:0] reg_rdata_out, all_ones_out;
	wire [6:0] pulse_segment_eight_out;
	wire receive_line_clock_in, transmit_line_clock_in, transmit_positive_rail_in;
	wire transmit_negative_rail_in, receive_positive_rail_out, receive_negative_rail_out;
	wire line_positive_out, line_negative_out, pulse_segment_active_out, rail_select_out;
	wire line_interrupt_out, internal_reset_b_out;
	integer mismatches = 0, num_checks = 0, i;
	line_unit_global_control line_unit_global_control_i(
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
		.reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.receive_signal_loss_in(receive_signal_loss_in),
		.equalizer_control_in(equalizer_control_in), .source_status_in(source_status_in),
		.source_enable_in(source_enable_in), .receive_line_clock_in(receive_line_clock_in),
		.transmit_line_clock_in(transmit_line_clock_in),
		.transmit_positive_rail_in(transmit_positive_rail_in),
		.transmit_negative_rail_in(transmit_negative_rail_in),
		.recovered_positive_in(recovered_positive_in),
		.recovered_negative_in(recovered_negative_in),
		.receive_positive_rail_out(receive_positive_rail_out),
		.receive_negative_rail_out(receive_negative_rail_out),
		.line_positive_out(line_positive_out), .line_negative_out(line_negative_out),
		.pulse_segment_eight_out(pulse_segment_eight_out),
		.pulse_segment_active_out(pulse_segment_active_out),
		.rail_select_out(rail_select_out), .all_ones_out(all_ones_out),
		.line_interrupt_out(line_interrupt_out), .internal_reset_b_out(internal_reset_b_out));
	framer_link_model framer_link_model_i(.run_in(run), .tx_edge_in(pol), .pol_in(pol),
		.bits_in(bits), .clk_out(transmit_line_clock_in),
		.rails_out({transmit_positive_rail_in, transmit_negative_rail_in}));
	assign receive_line_clock_in = transmit_line_clock_in;
	initial forever #20 sys_clk_in = ~sys_clk_in;
	// roughly sixty times the expected run
	initial begin #1000000; mismatches = mismatches + 1; finish_test; end
	task chk(input [7:0] seen, input [7:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task idle(input integer n); repeat (n) @(posedge sys_clk_in); #5; endtask
	task wr(input [11:0] a, input [7:0] d);
		@(posedge sys_clk_in);
		{reg_sel_in, reg_wr_in, reg_addr_in, reg_wdata_in} <= {2'b11, a, d};
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task rd(input [11:0] a, input [7:0] e);
		@(posedge sys_clk_in);
		{reg_sel_in, reg_addr_in} <= {1'b1, a};
		#5 chk(reg_rdata_out, e);
	endtask
	task wait_rst(input v);
		for (i = 0; i < 40 && internal_reset_b_out !== v; i = i + 1)
			idle(1);
		chk(internal_reset_b_out, v);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		rd(12'hfe0, 8'h00);
		rd(12'hfe8, 8'h00);
		rd(12'h123, 8'h00);
		wr(12'hfe8, 8'h45);
		wr(12'hfe0, 8'h01);
		idle(240);
		wait_rst(1'b1);
		wait_rst(1'b0);
		rd(12'hfe8, 8'h45);
		rd(12'hfe0, 8'h01);
		wr(12'hfe0, 8'h00);
		wait_rst(1'b1);
		$display("soft reset test done");
		wr(12'hfe0, 8'hfe);
		rd(12'hfe0, 8'hfa);
		chk(rail_select_out, 1'b1);
		@(posedge sys_clk_in);
		{equalizer_control_in, receive_signal_loss_in} <= {5'h1f, 8'ha5};
		idle(2);
		chk(pulse_segment_eight_out, 7'h45);
		chk(all_ones_out, 8'ha5);
		for (i = 0; i < 4; i = i + 1)
		begin
			if (i == 2)
				wr(12'hfe0, 8'h00);
			@(posedge sys_clk_in);
			{source_status_in, source_enable_in} <= {8'h0f, i[0] ? 8'h08 : 8'hf0};
			idle(3);
			chk(line_interrupt_out, i == 1);
		end
		chk(all_ones_out, 8'h00);
		@(posedge sys_clk_in);
		equalizer_control_in <= 5'h00;
		idle(2);
		chk(pulse_segment_eight_out, 7'h00);
		$display("control test done");
		for (i = 0; i < 2; i = i + 1)
		begin
			wr(12'hfe0, {2'b00, i[0], i[0], i[0], i[0], 2'b00});
			@(posedge sys_clk_in);
			{pol, run, bits, recovered_positive_in, recovered_negative_in} <= {i[0], 1'b1, ~i[0], i[0], 1'b1, i[0]};
			idle(30);
			chk({receive_positive_rail_out, receive_negative_rail_out}, {~i[0], 1'b0});
			chk({line_positive_out, line_negative_out}, {~i[0], i[0]});
			run <= 1'b0;
			idle(10);
		end
		$display("link test done");
		finish_test;
	end
endmodule // test_line_unit_global_control
